// File: hdl/bsxd_decoder.sv
// decode and execute of branch-on-negative, test-register-skip-zero, xor literal
// assumes program memory holds instr stable for a whole cycle and the register
// file answers reg_rdata combinationally for reg_addr
module bsxd_decoder (
   input wire logic clk, // core clock
   input wire logic rst, // async reset, active high
   input wire logic [15:0] instr, // word executing this cycle
   input wire logic [15:0] next_instr_word, // prefetched word behind it
   input wire logic [bsxd_pkg::PC_W-1:0] instr_addr, // address of executing word
   input wire logic [3:0] bank_select_register, // current bank
   input wire logic [7:0] reg_rdata, // data read from register file
   input wire logic [7:0] work_in, // work register before the op
   input wire logic flag_n_in, // negative flag
   input wire logic flag_z_in, // zero flag
   output logic [11:0] reg_addr, // banked register address
   output logic reg_rd, // register read strobe in q2
   output logic [1:0] phase, // instruction phase
   output logic pc_load, // one-cycle pc write pulse in q4
   output logic [bsxd_pkg::PC_W-1:0] pc_target, // new pc value
   output logic flush, // prefetched word discarded (pulse)
   output logic work_we, // work register write pulse in q4
   output logic [7:0] work_out, // new work value
   output logic flag_we, // n and z write pulse in q4
   output logic flag_n_out, // new negative flag
   output logic flag_z_out, // new zero flag
   output logic stall // high while nop cycles run
);
   logic cycle_end;
   bsxd_pkg::bsxd_state_e state;
   bsxd_pkg::bsxd_state_e next_state;
   logic skip_two;

   // phase generator
   bsxd_phase u_phase (
      .clk(clk),
      .rst(rst),
      .phase(phase),
      .cycle_end(cycle_end)
   );

   // true for the first word of a two-word instruction
   function automatic logic is_two_word(input logic [15:0] w);
      is_two_word = (w[15:12] == bsxd_pkg::OP2_MOVE_FF) || (w[15:8] == bsxd_pkg::OP2_LOAD_FSR) ||
         (w[15:9] == bsxd_pkg::OP2_CALL) || (w[15:8] == bsxd_pkg::OP2_GOTO);
   endfunction

   // opcode decode, blocked during nop cycles
   wire executing = (state == bsxd_pkg::ST_EXEC);
   wire dec_branch = executing && (instr[15:8] == bsxd_pkg::OP_BRANCH_NEG); // see RQ1
   wire dec_test = executing && (instr[15:9] == bsxd_pkg::OP_TEST_SKIP); // see RQ4
   wire dec_xor = executing && (instr[15:8] == bsxd_pkg::OP_XOR_LIT); // see RQ7

   // banked address: bank bit low selects the access bank split
   wire use_bank = instr[8];
   wire access_hi = (instr[7:0] >= bsxd_pkg::ACCESS_SPLIT);
   wire [3:0] eff_bank = use_bank ? bank_select_register :
      (access_hi ? bsxd_pkg::ACCESS_SFR_BANK : bsxd_pkg::ACCESS_BANK); // see RQ6
   assign reg_addr = {eff_bank, instr[7:0]};
   assign reg_rd = dec_test && (phase == bsxd_pkg::Q2);

   // branch target: address plus two plus twice the signed offset
   // the offset is sign-extended and doubled so targets stay on word boundaries
   wire [bsxd_pkg::PC_W-1:0] offset2 = {{(bsxd_pkg::PC_W - 9){instr[7]}}, instr[7:0], 1'b0};
   wire [bsxd_pkg::PC_W-1:0] next_pc_target = instr_addr + bsxd_pkg::PC_STEP + offset2; // see RQ2
   wire take_branch = dec_branch && flag_n_in; // see RQ3
   wire do_skip = dec_test && (reg_rdata == 8'h00); // see RQ4
   wire [7:0] xor_res = work_in ^ instr[7:0]; // see RQ7

   // nop cycles after a taken branch or a skip
   // decisions are only taken at cycle_end so a cycle is never cut short
   always_comb begin
      next_state = state;
      case (state)
         bsxd_pkg::ST_EXEC: begin
            if (cycle_end && (take_branch || do_skip)) begin
               next_state = bsxd_pkg::ST_NOP1; // see RQ3
            end
         end
         bsxd_pkg::ST_NOP1: begin
            if (cycle_end) begin
               next_state = skip_two ? bsxd_pkg::ST_NOP2 : bsxd_pkg::ST_EXEC; // see RQ5
            end
         end
         bsxd_pkg::ST_NOP2: begin
            if (cycle_end) begin
               next_state = bsxd_pkg::ST_EXEC;
            end
         end
         default: next_state = bsxd_pkg::ST_EXEC;
      endcase
   end

   // state and skip length
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= bsxd_pkg::ST_EXEC;
         skip_two <= 1'b0;
      end else begin
         state <= next_state;
         if (cycle_end && executing) begin
            skip_two <= do_skip && is_two_word(next_instr_word); // see RQ5
         end
      end
   end

   // q4 write-back pulses and data from flops
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pc_load <= 1'b0;
         pc_target <= '0;
         flush <= 1'b0;
         work_we <= 1'b0;
         work_out <= 8'h00;
         flag_we <= 1'b0;
         flag_n_out <= 1'b0;
         flag_z_out <= 1'b0;
      end else begin
         pc_load <= (phase == bsxd_pkg::Q3) && take_branch; // see RQ3
         flush <= (phase == bsxd_pkg::Q3) && (take_branch || do_skip); // see RQ4
         work_we <= (phase == bsxd_pkg::Q3) && dec_xor; // see RQ7
         flag_we <= (phase == bsxd_pkg::Q3) && dec_xor; // see RQ1
         if (phase == bsxd_pkg::Q3) begin
            pc_target <= next_pc_target;
            work_out <= xor_res;
            flag_n_out <= xor_res[7]; // see RQ8
            flag_z_out <= (xor_res == 8'h00); // see RQ8
         end
      end
   end

   // nop cycles hold the decoder off; the fetch side waits on this level
   assign stall = !executing;

   // taken branch writes pc one edge after q3 of the same cycle
   a_branch_pc_write: assert property (@(posedge clk) disable iff (rst) // see RQ2
      (phase == bsxd_pkg::Q3 && take_branch) |=> pc_load && pc_target == $past(next_pc_target))
      else $error("taken branch did not load pc");

   // untaken branch leaves pc alone in q4
   a_branch_no_pc: assert property (@(posedge clk) disable iff (rst) // see RQ3
      (phase == bsxd_pkg::Q3 && dec_branch && !flag_n_in) |=> !pc_load)
      else $error("untaken branch wrote pc");

   // untaken branch costs a single cycle, no nop follows
   a_untaken_one_cycle: assert property (@(posedge clk) disable iff (rst) // see RQ3
      (cycle_end && dec_branch && !flag_n_in) |=> !stall)
      else $error("untaken branch stalled");

   // taken branch spends exactly one full cycle of nops
   a_branch_nop_len: assert property (@(posedge clk) disable iff (rst) // see RQ3
      (cycle_end && take_branch) |=> stall [*4] ##1 !stall)
      else $error("taken branch nop cycle wrong length");

   // branch and test never write work or flags
   a_flags_hold: assert property (@(posedge clk) disable iff (rst) // see RQ1 RQ4
      (phase == bsxd_pkg::Q3 && (dec_branch || dec_test)) |=> !flag_we && !work_we)
      else $error("branch or test changed flags");

   // a zero register drops the prefetched word and never touches pc
   a_skip_flush: assert property (@(posedge clk) disable iff (rst) // see RQ4
      (phase == bsxd_pkg::Q3 && do_skip) |=> flush && !pc_load)
      else $error("skip did not discard prefetched word");

   // a nonzero register keeps the prefetched word
   a_keep_prefetch: assert property (@(posedge clk) disable iff (rst) // see RQ4
      (phase == bsxd_pkg::Q3 && dec_test && reg_rdata != 8'h00) |=> !flush)
      else $error("test without skip discarded word");

   // skip over a one-word instruction costs one nop cycle
   a_skip_nop_len: assert property (@(posedge clk) disable iff (rst) // see RQ4
      (cycle_end && do_skip && !is_two_word(next_instr_word)) |=> stall [*4] ##1 !stall)
      else $error("one-word skip nop cycle wrong length");

   // skip over a two-word instruction costs two nop cycles
   a_skip_three: assert property (@(posedge clk) disable iff (rst) // see RQ5
      (cycle_end && do_skip && is_two_word(next_instr_word)) |=> stall [*8] ##1 !stall)
      else $error("two-word skip not three cycles");

   // bank bit low with a low offset lands in the lower access bank
   a_bank_access: assert property (@(posedge clk) disable iff (rst) // see RQ6
      (!instr[8] && !instr[7]) |-> reg_addr[11:8] == bsxd_pkg::ACCESS_BANK)
      else $error("access bank not forced");

   // bank bit low with a high offset lands in the upper access bank
   a_access_high: assert property (@(posedge clk) disable iff (rst) // see RQ6
      (dec_test && !instr[8] && instr[7]) |-> reg_addr[11:8] == bsxd_pkg::ACCESS_SFR_BANK)
      else $error("upper access bank not forced");

   // bank bit high follows the bank select register
   a_bank_select: assert property (@(posedge clk) disable iff (rst) // see RQ6
      (dec_test && instr[8]) |-> reg_addr[11:8] == bank_select_register)
      else $error("bank select register not used");

   // xor writes work with the literal applied in the same cycle
   a_xor_result: assert property (@(posedge clk) disable iff (rst) // see RQ7
      (phase == bsxd_pkg::Q3 && dec_xor) |=> work_we && work_out == ($past(work_in) ^ $past(instr[7:0])))
      else $error("xor result wrong");

   // xor flags follow the result
   a_xor_flags: assert property (@(posedge clk) disable iff (rst) // see RQ8
      work_we |-> flag_we && flag_n_out == work_out[7] && flag_z_out == (work_out == 8'h00))
      else $error("xor flags wrong");

   // xor is a one-cycle instruction, no nop follows
   a_xor_one_cycle: assert property (@(posedge clk) disable iff (rst) // see RQ7
      (cycle_end && dec_xor) |=> !stall)
      else $error("xor stalled");

   // write-back pulses only ever show in q4
   a_pulse_q4: assert property (@(posedge clk) disable iff (rst) // see RQ3
      (pc_load || flush || work_we || flag_we) |-> phase == bsxd_pkg::Q4)
      else $error("write-back pulse outside q4");

   // write-back pulses last a single clock
   a_pulse_single: assert property (@(posedge clk) disable iff (rst) // see RQ3
      (pc_load || flush || work_we || flag_we) |=> !(pc_load || flush || work_we || flag_we))
      else $error("write-back pulse longer than one clock");

   // nop cycles write nothing back
   a_nop_quiet: assert property (@(posedge clk) disable iff (rst) // see RQ3
      (phase == bsxd_pkg::Q3 && stall) |=> !pc_load && !flush && !work_we && !flag_we)
      else $error("nop cycle wrote back");

   // q4 is always followed by q1 of the next cycle
   a_phase_wrap: assert property (@(posedge clk) disable iff (rst) // see RQ3
      (phase == bsxd_pkg::Q4) |=> phase == bsxd_pkg::Q1)
      else $error("phase did not wrap to q1");
endmodule

// File: common/bsxd_pkg.sv
// constants for the branch / test-skip / xor-literal decoder
// assumes one core clock where four clock edges make one instruction cycle
// Operation
// RQ1 - negative branch opcode 1110 0110, signed low byte offset, flags untouched
// RQ2 - taken branch loads pc with branch address plus two plus twice offset
// RQ3 - taken branch costs two cycles, second all nops; not taken skips pc write
// RQ4 - test-skip on zero register discards prefetched word, runs nop, no flags
// RQ5 - skip over a two-word instruction costs three cycles in total
// RQ6 - bank bit zero uses fixed access bank, one uses bank select register
// RQ7 - xor literal into work register in one cycle, only n and z change
// RQ8 - negative flag is result bit seven, zero flag set when result is zero
package bsxd_pkg;
   localparam int PC_W = 21;
   localparam logic [7:0] OP_BRANCH_NEG = 8'he6;
   localparam logic [6:0] OP_TEST_SKIP = 7'h33;
   localparam logic [7:0] OP_XOR_LIT = 8'h0a;
   // first-word prefixes of two-word instructions
   localparam logic [3:0] OP2_MOVE_FF = 4'hc;
   localparam logic [7:0] OP2_LOAD_FSR = 8'hee;
   localparam logic [6:0] OP2_CALL = 7'h76;
   localparam logic [7:0] OP2_GOTO = 8'hef;
   localparam logic [3:0] ACCESS_BANK = 4'h0;
   localparam logic [3:0] ACCESS_SFR_BANK = 4'hf;
   localparam logic [7:0] ACCESS_SPLIT = 8'h80;
   localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
   localparam logic [1:0] Q1 = 2'h0;
   localparam logic [1:0] Q2 = 2'h1;
   localparam logic [1:0] Q3 = 2'h2;
   localparam logic [1:0] Q4 = 2'h3;
   typedef enum logic [2:0] {
      ST_EXEC = 3'h1,
      ST_NOP1 = 3'h2,
      ST_NOP2 = 3'h4
   } bsxd_state_e;
endpackage

// File: hdl/bsxd_phase.sv
// four-phase instruction cycle generator
// assumes the core clock and core reset of the decoder
module bsxd_phase (
   input wire logic clk, // core clock
   input wire logic rst, // async reset, active high
   output logic [1:0] phase, // current phase, q1 to q4
   output logic cycle_end // high in the fourth phase
);
   // phase counter wraps every four edges
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         phase <= bsxd_pkg::Q1;
      end else begin
         phase <= phase + 2'h1;
      end
   end

   assign cycle_end = (phase == bsxd_pkg::Q4);
endmodule

// File: tb/bsxd_prog_mem.sv
// program memory model feeding the executing and prefetched words
// assumes byte addresses, words on even addresses, a small wrapping store
module bsxd_prog_mem (
   input wire logic [20:0] addr, // byte address of executing word
   output logic [15:0] word, // executing word
   output logic [15:0] next_word // prefetched word behind it
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] mem [0:15];
   // empty store reads as zero words so no stray two-word prefix appears
   initial begin
      for (int i = 0; i < 16; i++) mem[i] = 16'h0000;
   end
   // word and the one behind it
   assign word = mem[addr[4:1]];
   assign next_word = mem[addr[4:1] + 4'h1];
endmodule

// File: tb/tb_top.sv
// self-checking bench for the branch / test-skip / xor decoder
// assumes the memory model feeds words and this bench plays the register file
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst = 1'b1, fn = 1'b0, fz = 1'b0;
   logic [20:0] pc = 21'h00001e;
   logic [3:0] bank = 4'h0;
   logic [7:0] rdata = 8'h00, work = 8'h00, wo;
   logic [15:0] iw, nw;
   logic [11:0] raddr;
   logic rrd, pl, fl, wwe, fwe, no, zo, st;
   logic [1:0] ph;
   logic [20:0] tgt;
   int num_errors = 0, samples_checked = 0;
   // 4 ns core clock
   always #2 clk = ~clk;
   bsxd_prog_mem prog (.addr(pc), .word(iw), .next_word(nw));
   bsxd_decoder uut (.clk(clk), .rst(rst), .instr(iw), .next_instr_word(nw), .instr_addr(pc),
      .bank_select_register(bank), .reg_rdata(rdata), .work_in(work), .flag_n_in(fn), .flag_z_in(fz),
      .reg_addr(raddr), .reg_rd(rrd), .phase(ph), .pc_load(pl), .pc_target(tgt), .flush(fl), .work_we(wwe),
      .work_out(wo), .flag_we(fwe), .flag_n_out(no), .flag_z_out(zo), .stall(st));
   // compare and count
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one instruction from a q1 start, watched over four cycles
   task automatic run(input logic [20:0] a, input logic [15:0] w, input logic [15:0] n2, input logic n,
      input logic [7:0] rd, input logic [7:0] wk, input logic [3:0] bk, input logic [4:0] e, input int es,
      input logic [31:0] ev);
      logic [4:0] seen;
      logic [31:0] val;
      int ns;
      seen = 5'h00;
      val = 32'h0;
      ns = 0;
      @(posedge clk iff ph === bsxd_pkg::Q4);
      prog.mem[a[4:1]] <= w;
      prog.mem[a[4:1] + 4'h1] <= n2;
      pc <= a;
      fn <= n;
      rdata <= rd;
      work <= wk;
      bank <= bk;
      for (int i = 1; i <= 16; i++) begin
         @(posedge clk);
         if (i == 4) pc <= 21'h00001e;
         #1;
         seen = seen | {pl, fl, wwe, fwe, rrd};
         if (st === 1'b1) ns++;
         if (pl === 1'b1) val = 32'(tgt);
         if (wwe === 1'b1) val = {22'h0, wo, no, zo};
         if (rrd === 1'b1) val = 32'(raddr);
      end
      cmp(32'(seen), 32'(e));
      cmp(32'(ns), 32'(es));
      cmp(val, ev);
      cmp(32'(ph), 32'(bsxd_pkg::Q1));
   endtask
   // forward, most negative offset, and not taken
   task automatic t_branch;
      run(21'h000010, 16'he605, 16'h0000, 1'b1, 8'h00, 8'h00, 4'h0, 5'h18, 4, 32'h1c);
      run(21'h000200, 16'he680, 16'h0000, 1'b1, 8'h00, 8'h00, 4'h0, 5'h18, 4, 32'h102);
      run(21'h000010, 16'he605, 16'h0000, 1'b0, 8'h00, 8'h00, 4'h0, 5'h00, 0, 32'h0);
      $display("test branch done");
   endtask
   // skip over one- and two-word words, both bank modes, no skip
   task automatic t_skip;
      run(21'h000040, 16'h6690, 16'h0000, 1'b1, 8'h00, 8'h00, 4'h5, 5'h09, 4, 32'hf90);
      run(21'h000040, 16'h6712, 16'hef00, 1'b1, 8'h00, 8'h00, 4'h5, 5'h09, 8, 32'h512);
      run(21'h000040, 16'h6712, 16'hc123, 1'b1, 8'h00, 8'h00, 4'h5, 5'h09, 8, 32'h512);
      run(21'h000040, 16'h6712, 16'hee10, 1'b1, 8'h00, 8'h00, 4'h5, 5'h09, 8, 32'h512);
      run(21'h000040, 16'h6712, 16'hec05, 1'b1, 8'h00, 8'h00, 4'h5, 5'h09, 8, 32'h512);
      run(21'h000040, 16'h6612, 16'h0000, 1'b0, 8'h01, 8'h00, 4'h5, 5'h01, 0, 32'h012);
      $display("test skip done");
   endtask
   // plain, zero and negative results
   task automatic t_xor;
      run(21'h000040, 16'h0aaf, 16'h0000, 1'b0, 8'h00, 8'hb5, 4'h0, 5'h06, 0, 32'h068);
      run(21'h000040, 16'h0a5a, 16'h0000, 1'b0, 8'h00, 8'h5a, 4'h0, 5'h06, 0, 32'h001);
      run(21'h000040, 16'h0a80, 16'h0000, 1'b0, 8'h00, 8'h00, 4'h0, 5'h06, 0, 32'h202);
      $display("test xor done");
   endtask
   // verdict and end of run
   task automatic test_done;
      $display("checked %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // reset, then the scenarios
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      t_branch;
      t_skip;
      t_xor;
      test_done;
   end
   // watchdog, about six times the expected run
   initial begin
      #6000;
      num_errors++;
      test_done;
   end
endmodule
